/* File: verilog/csg_send_glue.sv */
// csg_send_glue: send service glue of a multi-line character controller.
// assumes pins arrive asynchronously, line units are on this clock's
// fan-out, and software reaches the switches and status over APB.
// Operation
// - address match needs switches equal and mode
// - compare eight switch bits to address lines
// - module select follows bit 13 or inverted qualifier
// - top scanner bits decode to unit one-hot
// - send data from bus 16-23 or panel
// - each data bit fanned to all units
// - five send clocks generated, buffered per unit
// - receive service request sets service flop
// - fast service set by service and fast
// - high-speed request toggled by enable, disable
// - preset set term is four-way AND
// - preset forces send scanner to 63
// - status one to carry, two to overflow
// - busy set by term, reset term clears
// - start accept term drives response line
// - sync test is four-way AND
// - panel coincidence is request AND flag
// - service call driver, panel uses call-on
// - send interrupt raised to processor
// - combine inverted unit requests and status
`timescale 1ns/1ps
`default_nettype none
module csg_send_glue (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // direct i/o bus receivers
    input wire logic [csg_pkg::ADDR_W-1:0] dioAddr,
    input wire logic [1:0] dioMode,
    input wire logic [25:16] dioData,
    input wire logic readWriteDirectIn,
    input wire logic startIoIn,
    input wire logic ioResetIn,
    input wire logic fsQualifier1,
    // controller qualifiers
    input wire logic ctrlAddrQual1,
    input wire logic ctrlAddrQual2,
    input wire logic ctrlAddrFlag,
    input wire logic zeroFlagN,
    input wire logic recvServiceReq,
    input wire logic fmt3FastCond,
    input wire logic hsReqEnable,
    input wire logic hsReqDisable,
    input wire logic sendScanEn,
    // maintenance test panel
    input wire logic panelInControl,
    input wire logic [csg_pkg::DATA_W-1:0] panelData,
    input wire logic serviceCallOn,
    // from line interface units
    input wire logic [csg_pkg::N_UNIT-1:0] unitSendReqN,
    input wire logic [csg_pkg::N_UNIT-1:0] unitStatus1N,
    input wire logic [csg_pkg::N_UNIT-1:0] unitStatus2N,
    // to line interface units
    output logic [csg_pkg::N_UNIT*csg_pkg::DATA_W-1:0] sendDataUnit,
    output logic [csg_pkg::N_UNIT-1:0] sendClkFmt1,
    output logic [csg_pkg::N_UNIT-1:0] sendClkFmt2,
    output logic [csg_pkg::N_UNIT-1:0] sendClkFmt3,
    output logic [csg_pkg::N_UNIT-1:0] sendClkFmt4,
    output logic [csg_pkg::N_UNIT-1:0] unitSelectOnehot,
    output logic sendModuleSel,
    output logic [csg_pkg::SCAN_W-1:0] sendScannerBits,
    output logic sendScannerToMax,
    // to i/o processor
    output logic devAddrMatch,
    output logic carryCc,
    output logic overflowCc,
    output logic ioResponseLine,
    output logic lowPrioServiceCall,
    output logic sendIrq,
    output logic syncTest,
    output logic panelCoincidence
);
    import csg_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // one-hot decode of a unit code; used for select lines and status
    function automatic logic [N_UNIT-1:0] unit_dec(logic [SEL_W-1:0] c);
        logic [N_UNIT-1:0] v;
        v = '0;
        v[c] = 1'b1;
        return v;
    endfunction

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    logic [PIN_W-1:0] pinRaw;       // every asynchronous input
    logic [PIN_W-1:0] pinS1_r;      // first stage, read by stage two only
    logic [PIN_W-1:0] pinS2_r;
    logic [PIN_W-1:0] pinS3_r;
    logic [PIN_W-1:0] pinF_r;       // filtered value
    logic [PIN_W-1:0] pinF_nxt;
    assign pinRaw = {dioAddr, dioMode, dioData, readWriteDirectIn,
        startIoIn, ioResetIn, fsQualifier1, ctrlAddrQual1, ctrlAddrQual2,
        ctrlAddrFlag, zeroFlagN, recvServiceReq, fmt3FastCond, hsReqEnable,
        hsReqDisable, sendScanEn, panelInControl, panelData, serviceCallOn,
        unitSendReqN, unitStatus1N, unitStatus2N};
    // a bit changes only once stages two and three agree; rejects glitches
    assign pinF_nxt = ((pinS2_r ~^ pinS3_r) & pinS3_r)
        | ((pinS2_r ^ pinS3_r) & pinF_r);

    // filtered copies of the pins
    logic [ADDR_W-1:0] aAddr;
    logic [1:0] aMode;
    logic [25:16] aData;
    logic aRwd, aSio, aIoRst, aFsq, aQ1, aQ2, aFlag, aZfN, aRsr, aF3;
    logic aHsEn, aHsDis, aScan, aPanel, aScon;
    logic [DATA_W-1:0] aPanelData;
    logic [N_UNIT-1:0] aReqN, aSt1N, aSt2N;
    assign {aAddr, aMode, aData, aRwd, aSio, aIoRst, aFsq, aQ1, aQ2,
        aFlag, aZfN, aRsr, aF3, aHsEn, aHsDis, aScan, aPanel, aPanelData,
        aScon, aReqN, aSt1N, aSt2N} = pinF_r;

    // three-stage capture of the pins
    always_ff @(posedge clk) begin
        pinS1_r <= pinRaw;
        pinS2_r <= pinS1_r;
        pinS3_r <= pinS2_r;
        if (!reset_n) begin
            pinF_r <= pinS3_r; // settled pins, so no false event at release
        end else begin
            pinF_r <= pinF_nxt;
        end
    end

    // ------------------------------------------------------------
    // registers and apb slave
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_r;      // switches and option bits
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;
    logic setupPh, accessDone, wrCtrl, wrClr, hitCtrl, hitStat, hitClr;
    logic clrServ, clrBusy;
    logic [31:0] statWord, rdMux;
    logic [SW_W-1:0] addrSwitches;
    logic hsOption, irqEnable;
    assign setupPh = psel & ~penable;
    assign accessDone = psel & penable & pready_r;
    assign hitCtrl = (paddr == REG_CTRL);
    assign hitStat = (paddr == REG_STAT);
    assign hitClr = (paddr == REG_CLR);
    assign wrCtrl = accessDone & pwrite & hitCtrl;
    assign wrClr = accessDone & pwrite & hitClr;
    assign clrServ = wrClr & pwdata[CLR_SERVICE_FF];
    assign clrBusy = wrClr & pwdata[CLR_BUSY];
    assign addrSwitches = ctrl_r[SW_W-1:0];
    assign hsOption = ctrl_r[CTRL_HS];
    assign irqEnable = ctrl_r[CTRL_IRQ];

    // address decode for reads; clear register reads as zero
    always_comb begin
        if (hitCtrl) begin
            rdMux = {{(32-CTRL_W){1'b0}}, ctrl_r};
        end else if (hitStat) begin
            rdMux = statWord;
        end else begin
            rdMux = ZERO32;
        end
    end

    // answer lands in the first access cycle; pready is low in setup
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= ZERO32;
            ctrl_r <= CTRL_RST;
        end else begin
            pready_r <= setupPh;
            pslverr_r <= setupPh & ~(hitCtrl | hitStat | hitClr);
            if (setupPh) begin
                prdata_r <= rdMux;
            end
            if (wrCtrl) begin
                ctrl_r <= pwdata[CTRL_W-1:0];
            end
        end
    end
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // ------------------------------------------------------------
    // address match, select and data distribution
    // ------------------------------------------------------------
    logic matchNxt, modSelNxt, sendReq, st1, st2;
    logic [DATA_W-1:0] dataNxt;
    logic [N_UNIT-1:0] selNxt;
    logic [SCAN_W-1:0] scan_r;
    // bitwise compare of switches against the low address lines
    assign matchNxt = (aAddr[SW_W-1:0] == addrSwitches)
        & (aMode == MODE_PROPER);
    // unqualified accesses fall back to the inverted qualifier
    assign modSelNxt = aQ2 ? aAddr[BIT13] : ~aQ2;
    assign selNxt = unit_dec(scan_r[SCAN_W-1 -: SEL_W]);
    // the panel wins whenever it holds control
    assign dataNxt = aPanel ? aPanelData : aData[23:16];
    // any unit asking for send service raises the common request
    assign sendReq = |(~aReqN);
    // status reflects only the unit currently addressed
    assign st1 = |(~aSt1N & selNxt);
    assign st2 = |(~aSt2N & selNxt);

    // ------------------------------------------------------------
    // send clock dividers
    // ------------------------------------------------------------
    logic [N_FMT-1:0] clkLvl_r;
    genvar g;
    generate
        for (g = 0; g < N_FMT; g++) begin : gDiv
            // half period in cycles, rounded down, never below one
            localparam int HC = (FMT_HALF_NS[g] * CLK_MHZ) / 1000;
            localparam logic [DIV_W-1:0] HALF =
                DIV_W'((HC < 1) ? 1 : HC);
            localparam logic [DIV_W-1:0] DONE = HALF - DIV_W'(1);
            logic [DIV_W-1:0] cnt_r;
            // toggles the level every half period
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    cnt_r <= '0;
                    clkLvl_r[g] <= 1'b0;
                end else if (cnt_r == DONE) begin
                    cnt_r <= '0;
                    clkLvl_r[g] <= ~clkLvl_r[g];
                end else begin
                    cnt_r <= cnt_r + DIV_W'(1);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // service, high-speed and scanner flip-flops
    // ------------------------------------------------------------
    logic service_ff_r, fast_r, hs_r, preset_r, busy_r;
    logic presetSet, busySet, busyResetTermN, startAccept, hsNxt;
    // high-speed request only exists with the option fitted
    assign hsNxt = hsOption & (aHsEn | (hs_r & ~aHsDis));
    assign presetSet = sendReq & hs_r & aQ1 & aZfN;
    // accept a start only while idle
    assign startAccept = ~busy_r;
    assign busySet = aSio & matchNxt;
    // low-active: goes low once busy and no new set term is present
    assign busyResetTermN = ~(busy_r & ~busySet);

    // io reset clears the service and busy state ahead of any set; otherwise sets win over clears
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            service_ff_r <= 1'b0;
            fast_r <= 1'b0;
            hs_r <= 1'b0;
            busy_r <= 1'b0;
        end else if (aIoRst) begin
            service_ff_r <= 1'b0;
            fast_r <= 1'b0;
            hs_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            service_ff_r <= aRsr | (service_ff_r & ~clrServ);
            fast_r <= (service_ff_r & aF3) | (fast_r & ~clrServ);
            hs_r <= hsNxt;
            if (busySet) begin
                busy_r <= 1'b1;
            end else if (!busyResetTermN || clrBusy) begin
                busy_r <= 1'b0;
            end
        end
    end

    // scanner preset follows its set term; the scanner is held at 63 while it is set
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            preset_r <= 1'b0;
            scan_r <= SCAN_ZERO;
        end else if (preset_r) begin
            preset_r <= presetSet;
            scan_r <= SCAN_MAX;
        end else begin
            preset_r <= presetSet;
            if (aScan) begin
                // wraps 63 to 0 so channels 0-7 come first
                scan_r <= scan_r + SCAN_ONE;
            end
        end
    end

    // live state for software
    assign statWord = {{(32-SCAN_W-10){1'b0}}, scan_r, st2, st1,
        sendReq, matchNxt, preset_r, hs_r, fast_r, service_ff_r, busy_r, aPanel};

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sendDataUnit <= '0;
            sendClkFmt1 <= '0;
            sendClkFmt2 <= '0;
            sendClkFmt3 <= '0;
            sendClkFmt4 <= '0;
            unitSelectOnehot <= '0;
            sendModuleSel <= 1'b0;
            devAddrMatch <= 1'b0;
            carryCc <= 1'b0;
            overflowCc <= 1'b0;
            ioResponseLine <= 1'b0;
            lowPrioServiceCall <= 1'b0;
            sendIrq <= 1'b0;
            syncTest <= 1'b0;
            panelCoincidence <= 1'b0;
        end else begin
            sendDataUnit <= {N_UNIT{dataNxt}};
            sendClkFmt1 <= {N_UNIT{clkLvl_r[FMT1]}};
            sendClkFmt2 <= {N_UNIT{clkLvl_r[FMT2]}};
            // format III units take the fast or slow clock
            sendClkFmt3 <= {N_UNIT{aF3 ? clkLvl_r[FMT3F]
                : clkLvl_r[FMT3S]}};
            sendClkFmt4 <= {N_UNIT{clkLvl_r[FMT4]}};
            unitSelectOnehot <= selNxt;
            sendModuleSel <= modSelNxt;
            devAddrMatch <= matchNxt;
            carryCc <= st1;
            overflowCc <= st2;
            ioResponseLine <= busySet & startAccept;
            lowPrioServiceCall <= aPanel ? aScon
                : (sendReq | service_ff_r);
            sendIrq <= irqEnable & sendReq;
            syncTest <= aFsq & aData[24] & aData[25] & aRwd;
            panelCoincidence <= sendReq & aFlag;
        end
    end
    assign sendScannerBits = scan_r;
    assign sendScannerToMax = preset_r;
endmodule
`default_nettype wire

/* File: verilog/csg_pkg.sv */
// csg_pkg: constants shared by the send service glue block.
// assumes a single 125 MHz controller clock and an APB register port.
package csg_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;        // controller clock rate
    localparam int N_FMT = 5;            // send clock formats generated
    // send clock half periods in ns, per format (1, 2, 3 fast, 3 slow, 4)
    localparam int FMT_HALF_NS [N_FMT] = '{4000, 2000, 800, 8000, 1000};
    localparam int FMT1 = 0;             // index of format I clock
    localparam int FMT2 = 1;             // index of format II clock
    localparam int FMT3F = 2;            // index of format III fast clock
    localparam int FMT3S = 3;            // index of format III slow clock
    localparam int FMT4 = 4;             // index of format IV clock
    localparam int DIV_W = 16;           // width of each divider counter

    // ------------------------------------------------------------
    // widths and bus constants
    // ------------------------------------------------------------
    localparam int N_UNIT = 8;           // line interface units
    localparam int SEL_W = 3;            // unit select code width
    localparam int SCAN_W = 6;           // send scanner width
    localparam int DATA_W = 8;           // send data bits
    localparam int ADDR_W = 16;          // direct bus address lines
    localparam int SW_W = 8;             // address switch bits
    localparam int BIT13 = 13;           // send module select address line
    localparam int PIN_W = 75;           // synchronised pin inputs in total
    localparam logic [1:0] MODE_PROPER = 2'h3;          // bus mode to match
    localparam logic [SCAN_W-1:0] SCAN_MAX = 6'h3F;     // preset value 63
    localparam logic [SCAN_W-1:0] SCAN_ZERO = 6'h00;
    localparam logic [SCAN_W-1:0] SCAN_ONE = 6'h01;

    // ------------------------------------------------------------
    // APB register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;   // switches and options
    localparam logic [7:0] REG_STAT = 8'h04;   // live block state
    localparam logic [7:0] REG_CLR = 8'h08;    // write-one clears
    localparam int CTRL_HS = 8;          // high-speed option enable
    localparam int CTRL_IRQ = 9;         // send interrupt enable
    localparam int CTRL_W = 10;          // implemented control bits
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
    localparam int CLR_SERVICE_FF = 0;         // clear service flip-flops
    localparam int CLR_BUSY = 1;         // clear busy flip-flop
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage

/* File: test/csg_iop_model.sv */
// csg_iop_model: behavioural i/o processor on the direct bus pins.
// assumes the bench calls drive from a single process only.
`timescale 1ns/1ps
`default_nettype none
module csg_iop_model (
    // clock
    input wire logic clk,
    // direct bus toward the controller
    output logic [15:0] dioAddr,
    output logic [1:0] dioMode,
    output logic [25:16] dioData,
    output logic readWriteDirectIn,
    output logic startIoIn,
    output logic ioResetIn,
    output logic fsQualifier1
);
    // every line idle at time zero
    initial begin
        {dioAddr, dioMode, dioData} = '0;
        {readWriteDirectIn, startIoIn, ioResetIn, fsQualifier1} = '0;
    end
    // one bus state, launched just after an edge and then held;
    // ctl is {function strobe, read/write, start, io reset}
    task automatic drive(input logic [15:0] a, input logic [1:0] m,
        input logic [9:0] d, input logic [3:0] ctl);
        @(posedge clk);
        dioAddr <= a;
        dioMode <= m;
        dioData <= d;
        {fsQualifier1, readWriteDirectIn} <= ctl[3:2];
        {startIoIn, ioResetIn} <= ctl[1:0];
    endtask
endmodule
`default_nettype wire

/* File: test/csg_send_glue_chk.sv */
// csg_send_glue_chk: port-level assertions for the send glue block.
// assumes the bind below; pins need about five cycles to show.
`timescale 1ns/1ps
`default_nettype none
module csg_send_glue_chk (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // pins in
    input wire logic [25:16] dioData,
    input wire logic readWriteDirectIn,
    input wire logic fsQualifier1,
    input wire logic panelInControl,
    input wire logic serviceCallOn,
    // outputs watched
    input wire logic [csg_pkg::N_UNIT*csg_pkg::DATA_W-1:0] sendDataUnit,
    input wire logic [csg_pkg::N_UNIT-1:0] sendClkFmt1,
    input wire logic [csg_pkg::N_UNIT-1:0] sendClkFmt2,
    input wire logic [csg_pkg::N_UNIT-1:0] sendClkFmt3,
    input wire logic [csg_pkg::N_UNIT-1:0] sendClkFmt4,
    input wire logic [csg_pkg::N_UNIT-1:0] unitSelectOnehot,
    input wire logic [csg_pkg::SCAN_W-1:0] sendScannerBits,
    input wire logic sendScannerToMax,
    input wire logic devAddrMatch,
    input wire logic syncTest,
    input wire logic lowPrioServiceCall
);
    import csg_pkg::*;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    // four-way term; seven steady samples cover the pin filter
    wire logic syncIn = fsQualifier1 & dioData[24] & dioData[25] &
        readWriteDirectIn;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_reset_quiet: assert property ($rose(reset_n) |-> !pready &&
        !devAddrMatch && !syncTest && sendDataUnit == '0)
        else $error("outputs not quiet after reset");
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no ready one cycle after setup");
    a_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
        else $error("ready outside a single access cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_data_fanout: assert property (sendDataUnit ==
        {N_UNIT{sendDataUnit[7:0]}}) else $error("data copies differ");
    a_clk_fanout: assert property ((sendClkFmt1 == '0 ||
        sendClkFmt1 == '1) && (sendClkFmt2 == '0 || sendClkFmt2 == '1) &&
        (sendClkFmt3 == '0 || sendClkFmt3 == '1) &&
        (sendClkFmt4 == '0 || sendClkFmt4 == '1))
        else $error("send clock copies differ");
    a_unit_onehot: assert property ($past(reset_n, 2) |->
        $onehot(unitSelectOnehot)) else $error("unit select not one-hot");
    a_preset_load: assert property (sendScannerToMax &&
        $past(sendScannerToMax) |-> sendScannerBits == SCAN_MAX)
        else $error("scanner not held at top");
    a_sync_on: assert property (syncIn [*7] |-> syncTest)
        else $error("sync test missing");
    a_sync_off: assert property (!syncIn [*7] |-> !syncTest)
        else $error("sync test spurious");
    a_panel_call: assert property ((panelInControl &&
        serviceCallOn) [*7] |-> lowPrioServiceCall)
        else $error("panel service call missing");
endmodule
bind csg_send_glue csg_send_glue_chk csg_send_glue_chk_inst (.clk,
    .reset_n, .psel, .penable, .pready, .pslverr, .dioData,
    .readWriteDirectIn, .fsQualifier1, .panelInControl, .serviceCallOn,
    .sendDataUnit, .sendClkFmt1, .sendClkFmt2, .sendClkFmt3, .sendClkFmt4,
    .unitSelectOnehot, .sendScannerBits, .sendScannerToMax, .devAddrMatch,
    .syncTest, .lowPrioServiceCall);
`default_nettype wire

/* File: test/csg_send_glue_tb.sv */
// csg_send_glue_tb: directed bench, apb master plus pin sequences.
// assumes the i/o processor model drives the direct bus pins.
`timescale 1ns/1ps
`default_nettype none
module csg_send_glue_tb;
    import csg_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = ZERO32, prdata, rd;
    logic ctrlAddrQual1 = 1'b0, ctrlAddrQual2 = 1'b0, ctrlAddrFlag = 1'b0;
    logic zeroFlagN = 1'b1, recvServiceReq = 1'b0, fmt3FastCond = 1'b0;
    logic hsReqEnable = 1'b0, hsReqDisable = 1'b0, sendScanEn = 1'b0;
    logic panelInControl = 1'b0, serviceCallOn = 1'b0;
    logic [7:0] panelData = 8'h00, unitSendReqN = 8'hFF;
    logic [7:0] unitStatus1N = 8'hFF, unitStatus2N = 8'hFF;
    logic [63:0] sendDataUnit;
    logic [5:0] sendScannerBits;
    logic [15:0] dioAddr;
    logic [1:0] dioMode;
    logic [25:16] dioData;
    logic readWriteDirectIn, startIoIn, ioResetIn, fsQualifier1;
    logic sendModuleSel, sendScannerToMax, devAddrMatch, carryCc;
    logic overflowCc, ioResponseLine, lowPrioServiceCall, sendIrq;
    logic syncTest, panelCoincidence;
    int errCount = 0, cmpCount = 0;
    // 125 MHz controller clock
    always #4 clk = ~clk;
    csg_send_glue csg_send_glue_inst (.clk, .reset_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dioAddr,
        .dioMode, .dioData, .readWriteDirectIn, .startIoIn, .ioResetIn,
        .fsQualifier1, .ctrlAddrQual1, .ctrlAddrQual2, .ctrlAddrFlag,
        .zeroFlagN, .recvServiceReq, .fmt3FastCond, .hsReqEnable,
        .hsReqDisable, .sendScanEn, .panelInControl, .panelData,
        .serviceCallOn, .unitSendReqN, .unitStatus1N, .unitStatus2N,
        .sendDataUnit, .sendClkFmt1(), .sendClkFmt2(), .sendClkFmt3(),
        .sendClkFmt4(), .unitSelectOnehot(), .sendModuleSel,
        .sendScannerBits, .sendScannerToMax, .devAddrMatch, .carryCc,
        .overflowCc, .ioResponseLine, .lowPrioServiceCall, .sendIrq,
        .syncTest, .panelCoincidence);
    csg_iop_model csg_iop_model_inst (.clk, .dioAddr, .dioMode, .dioData,
        .readWriteDirectIn, .startIoIn, .ioResetIn, .fsQualifier1);
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmpCount++;
        if (g !== e) begin
            errCount++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic chkB(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask
    // one apb transfer; request held until ready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // bus state, then time for the pin filters and output flops
    task automatic pin(input logic [15:0] a, input logic [1:0] m,
        input logic [9:0] d, input logic [3:0] c);
        csg_iop_model_inst.drive(a, m, d, c);
        cyc(8);
    endtask
    task automatic finalReport;
        $display("comparisons %0d mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard, well past the tests' length
    initial begin
        #100000;
        errCount++;
        finalReport();
    end
    initial begin
        logic [3:0] c;
        int n;
        cyc(8);
        reset_n <= 1'b1;
        apb(1'b0, REG_CTRL, ZERO32);
        chk(rd, ZERO32);
        apb(1'b1, REG_CTRL, 32'h0000_035A);
        apb(1'b0, REG_CTRL, ZERO32);
        chk(rd, 32'h0000_035A);
        apb(1'b0, 8'h0C, 32'hFFFF_FFFF);
        chkB(er, 1'b1);
        chk(rd, ZERO32);
        pin(16'h205A, 2'h3, 10'h0A5, 4'h0);
        chkB(devAddrMatch, 1'b1);
        for (int i = 0; i < 8; i++) begin
            pin(16'h205A ^ (16'h0001 << i), 2'h3, 10'h0A5, 4'h0);
            chkB(devAddrMatch, 1'b0);
        end
        pin(16'h205A, 2'h2, 10'h0A5, 4'h0);
        chkB(devAddrMatch, 1'b0);
        chkB(sendModuleSel, 1'b1);
        ctrlAddrQual2 <= 1'b1;
        pin(16'h005A, 2'h3, 10'h0A5, 4'h0);
        chkB(sendModuleSel, 1'b0);
        chk(sendDataUnit[31:0], 32'hA5A5_A5A5);
        chk(sendDataUnit[63:32], 32'hA5A5_A5A5);
        panelInControl <= 1'b1;
        panelData <= 8'h3C;
        pin(16'h205A, 2'h3, 10'h0A5, 4'h0);
        chkB(sendModuleSel, 1'b1);
        chk(sendDataUnit[63:32], 32'h3C3C_3C3C);
        chkB(lowPrioServiceCall, 1'b0);
        serviceCallOn <= 1'b1;
        cyc(8);
        chkB(lowPrioServiceCall, 1'b1);
        panelInControl <= 1'b0;
        serviceCallOn <= 1'b0;
        // drop each of the four sync inputs in turn, then none
        for (int k = 0; k < 5; k++) begin
            c = (k == 4) ? 4'hF : (4'hF & ~(4'h1 << k));
            pin(16'h205A, 2'h3, {c[1:0], 8'hA5}, {c[3:2], 2'b00});
            chkB(syncTest, c == 4'hF);
        end
        csg_iop_model_inst.drive(16'h205A, 2'h3, 10'h0A5, 4'h2);
        n = 0;
        while (ioResponseLine !== 1'b1 && n < 12) begin
            @(posedge clk);
            n++;
        end
        chkB(ioResponseLine, 1'b1);
        cyc(4);
        chkB(ioResponseLine, 1'b0);
        apb(1'b0, REG_STAT, ZERO32);
        chk(rd & 32'h2, 32'h2);
        pin(16'h205A, 2'h3, 10'h0A5, 4'h0);
        apb(1'b0, REG_STAT, ZERO32);
        chk(rd & 32'h2, ZERO32);
        recvServiceReq <= 1'b1;
        fmt3FastCond <= 1'b1;
        cyc(8);
        apb(1'b0, REG_STAT, ZERO32);
        chk(rd & 32'hC, 32'hC);
        recvServiceReq <= 1'b0;
        fmt3FastCond <= 1'b0;
        pin(16'h205A, 2'h3, 10'h0A5, 4'h1);
        pin(16'h205A, 2'h3, 10'h0A5, 4'h0);
        apb(1'b0, REG_STAT, ZERO32);
        chk(rd & 32'hC, ZERO32);
        recvServiceReq <= 1'b1;
        cyc(8);
        recvServiceReq <= 1'b0;
        apb(1'b0, REG_STAT, ZERO32);
        chk(rd & 32'h4, 32'h4);
        apb(1'b1, REG_CLR, 32'h0000_0001);
        apb(1'b0, REG_STAT, ZERO32);
        chk(rd & 32'h4, ZERO32);
        unitStatus1N <= 8'hFE;
        cyc(8);
        chkB(carryCc, 1'b1);
        chkB(overflowCc, 1'b0);
        unitStatus1N <= 8'hFD;
        unitStatus2N <= 8'hFE;
        cyc(8);
        chkB(carryCc, 1'b0);
        chkB(overflowCc, 1'b1);
        unitSendReqN <= 8'h00;
        ctrlAddrQual1 <= 1'b1;
        ctrlAddrFlag <= 1'b1;
        hsReqEnable <= 1'b1;
        cyc(8);
        hsReqEnable <= 1'b0;
        cyc(8);
        apb(1'b0, REG_STAT, ZERO32);
        chk(rd & 32'h30, 32'h30);
        chkB(sendScannerToMax, 1'b1);
        chk({26'h0, sendScannerBits}, {26'h0, SCAN_MAX});
        chkB(panelCoincidence, 1'b1);
        chkB(sendIrq, 1'b1);
        chkB(lowPrioServiceCall, 1'b1);
        apb(1'b1, REG_CTRL, 32'h0000_015A);
        cyc(4);
        chkB(sendIrq, 1'b0);
        hsReqDisable <= 1'b1;
        cyc(8);
        hsReqDisable <= 1'b0;
        cyc(8);
        apb(1'b0, REG_STAT, ZERO32);
        chk(rd & 32'h10, ZERO32);
        sendScanEn <= 1'b1;
        cyc(2);
        sendScanEn <= 1'b0;
        cyc(8);
        chk({26'h0, sendScannerBits}, {26'h0, SCAN_ONE});
        finalReport();
    end
endmodule
`default_nettype wire
